/* rtl/atc_timer.sv */
// Timer core: counter, prescaler, repetition, channel enable and polarity
// Function
// - Output channel enable 0 keeps pin inactive, 1 drives compare output.
// - Input channel enable gates capture of the counter into channel value.
// - Output polarity 0 active high, 1 active low for the main output.
// - Input polarity 0 uses input as is, 1 uses its inverse.
// - Polarity bits ignore writes while protection level is 2 or 3.
// - Complementary enable switches the inverted companion output off or on.
// - Complementary polarity 0 active high, 1 active low.
// - Channels 2 and 3 repeat channel 1's four-bit group at bits 4 and 8.
// - Channel 4 has enable and polarity at 12 and 13; bits 15:14 reserved.
// - Counter clock is input clock divided by prescale value plus one.
// - Counter holds while reload value is zero; reload resets to all ones.
// - Repetition counter reaching zero raises update, restarts from repeat value.
// - Written repeat value is shadowed until the next update event.
// - Direction select 00 is output, other codes pick different inputs.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module atc_timer #(
  parameter int CNT_W = 16,
  parameter int REP_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Channel pins
  input wire logic [3:0] i_chan_filtered_in,
  input wire logic i_trigger_in,
  output logic [3:0] o_chan_compare_out,
  output logic [3:0] o_chan_compare_oe,
  output logic [2:0] o_chan_compare_out_inv,
  output logic [2:0] o_chan_compare_inv_oe,
  // Events
  output logic o_update_event
);
  // Counter width is fixed by the map and repetition width limited to 1..16; others are refused at elaboration
  if (CNT_W != 16 || REP_W < 1 || REP_W > 16) begin : g_bad_width
    $error("atc_timer: unsupported width");
  end

  // Reset released through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Register state
  logic [2:0] ctrl_q;
  logic [7:0] dir_q;
  logic [15:0] ccen_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] psc_q;
  logic [CNT_W-1:0] psc_act_q;
  logic [CNT_W-1:0] reload_q;
  logic [REP_W-1:0] rep_shadow_q;
  logic [REP_W-1:0] rep_cnt_q;
  logic [CNT_W-1:0] chv_q [4];
  logic [3:0] src_prev_q;

  // Source of a channel's input for a direction code
  function automatic logic pick_source(input logic [1:0] dir, input logic own,
                                       input logic partner, input logic trig);
    case (dir)
      atc_pkg::DIR_IN_OWN: pick_source = own;
      atc_pkg::DIR_IN_PARTNER: pick_source = partner;
      atc_pkg::DIR_IN_TRIGGER: pick_source = trig;
      default: pick_source = 1'b0;
    endcase
  endfunction : pick_source

  // Bit position of a field within a channel group
  function automatic int field_pos(input int ch, input int pos);
    field_pos = ch * atc_pkg::CHAN_GROUP_W + pos;
  endfunction : field_pos

  // AHB address phase capture
  logic addr_ok;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic stall;
  assign addr_ok = i_hsel && i_htrans[atc_pkg::HTRANS_ACTIVE_BIT] && i_hready;
  // A read right behind a write waits one cycle so it sees the new value
  assign stall = wr_pend_q && i_hsel && i_htrans[atc_pkg::HTRANS_ACTIVE_BIT] && !i_hwrite;
  assign o_hreadyout = !stall;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && i_hwrite && !stall;
      wr_addr_q <= i_haddr[7:0];
    end
  end

  // Write strobes, taken in the data phase
  logic wr_ctrl, wr_dir, wr_ccen, wr_cnt, wr_psc, wr_reload, wr_rep;
  logic [3:0] wr_chv;
  logic in_map;
  assign in_map = wr_pend_q;
  assign wr_ctrl = in_map && wr_addr_q == atc_pkg::ADDR_CTRL;
  assign wr_dir = in_map && wr_addr_q == atc_pkg::ADDR_DIR;
  assign wr_ccen = in_map && wr_addr_q == atc_pkg::ADDR_CHAN_ENABLE_POLARITY;
  assign wr_cnt = in_map && wr_addr_q == atc_pkg::ADDR_COUNTER_VALUE;
  assign wr_psc = in_map && wr_addr_q == atc_pkg::ADDR_PRESCALE_DIVIDER;
  assign wr_reload = in_map && wr_addr_q == atc_pkg::ADDR_RELOAD_LIMIT;
  assign wr_rep = in_map && wr_addr_q == atc_pkg::ADDR_REPEAT_PERIOD;
  for (genvar c = 0; c < 4; c++) begin : g_wr_chv
    assign wr_chv[c] = in_map && wr_addr_q == atc_pkg::ADDR_CHAN_VALUE_BASE + 8'(4 * c);
  end

  // Control and direction select; direction is frozen while channel enabled
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= atc_pkg::RST_CTRL;
      dir_q <= atc_pkg::RST_DIR;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_hwdata[2:0];
      end
      if (wr_dir) begin
        for (int c = 0; c < 4; c++) begin
          if (!ccen_q[field_pos(c, atc_pkg::POS_ENABLE)]) begin
            dir_q[2*c +: 2] <= i_hwdata[2*c +: 2];
          end
        end
      end
    end
  end

  // Enable/polarity word with protected polarity bits
  logic [1:0] prot_level;
  logic [15:0] ccen_keep;
  assign prot_level = ctrl_q[atc_pkg::POS_PROT_LO +: 2];
  assign ccen_keep = (prot_level >= atc_pkg::PROT_LEVEL_GUARD) ?
                     atc_pkg::CCEN_POLARITY_MASK : 16'h0000;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccen_q <= atc_pkg::RST_CHAN_ENABLE_POLARITY;
    end else if (wr_ccen) begin
      // Reserved bits 15:14 stay zero
      ccen_q <= ((i_hwdata[15:0] & ~ccen_keep) | (ccen_q & ccen_keep))
                & atc_pkg::CCEN_WRITE_MASK;
    end
  end

  // Prescaler instance
  atc_tick_if #(.W(CNT_W)) tick ();
  atc_prescaler #(.W(CNT_W)) u_prescaler (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .tick(tick.prs)
  );

  // Counter, overflow and repetition
  logic count_en;
  logic overflow;
  logic update;
  assign count_en = ctrl_q[atc_pkg::POS_COUNT_ENABLE];
  // A zero reload value keeps the counter still
  assign overflow = count_en && tick.counter_clock && (reload_q != '0) &&
                    (cnt_q >= reload_q);
  assign update = overflow && (rep_cnt_q == '0);
  assign tick.prescale_value = psc_act_q;
  assign tick.restart = update;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= atc_pkg::RST_COUNTER_VALUE;
    end else if (wr_cnt) begin
      cnt_q <= i_hwdata[CNT_W-1:0];
    end else if (overflow) begin
      cnt_q <= '0;
    end else if (count_en && tick.counter_clock && reload_q != '0) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Prescale, reload and repetition registers; prescale and repetition with their shadows, reload written directly
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_q <= atc_pkg::RST_PRESCALE_DIVIDER;
      psc_act_q <= atc_pkg::RST_PRESCALE_DIVIDER;
      reload_q <= atc_pkg::RST_RELOAD_LIMIT;
      rep_shadow_q <= REP_W'(atc_pkg::RST_REPEAT_PERIOD);
    end else begin
      if (wr_psc) begin
        psc_q <= i_hwdata[CNT_W-1:0];
      end
      if (wr_reload) begin
        reload_q <= i_hwdata[CNT_W-1:0];
      end
      if (wr_rep) begin
        rep_shadow_q <= i_hwdata[REP_W-1:0];
      end
      if (update) begin
        psc_act_q <= psc_q;
      end
    end
  end

  // Down counter of overflows; new repeat value applies only at update
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_cnt_q <= REP_W'(atc_pkg::RST_REPEAT_PERIOD);
    end else if (update) begin
      rep_cnt_q <= rep_shadow_q;
    end else if (overflow) begin
      rep_cnt_q <= rep_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_update_event <= 1'b0;
    end else begin
      o_update_event <= update;
    end
  end

  // Channel input sources after polarity
  logic [3:0] src;
  logic [3:0] capture;
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      src[c] = pick_source(dir_q[2*c +: 2], i_chan_filtered_in[c],
                           i_chan_filtered_in[c ^ 1], i_trigger_in)
               ^ ccen_q[field_pos(c, atc_pkg::POS_POLARITY)];
      capture[c] = (dir_q[2*c +: 2] != atc_pkg::DIR_OUTPUT) && src[c] && !src_prev_q[c]
                   && ccen_q[field_pos(c, atc_pkg::POS_ENABLE)];
    end
  end

  // Edge history and channel values; a capture wins over a bus write
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        chv_q[c] <= '0;
      end
    end else begin
      src_prev_q <= src;
      for (int c = 0; c < 4; c++) begin
        if (capture[c]) begin
          chv_q[c] <= cnt_q;
        end else if (wr_chv[c]) begin
          chv_q[c] <= i_hwdata[CNT_W-1:0];
        end
      end
    end
  end

  // Compare outputs: reference is high while counter is below channel value
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_chan_compare_out <= 4'h0;
      o_chan_compare_oe <= 4'h0;
      o_chan_compare_out_inv <= 3'h0;
      o_chan_compare_inv_oe <= 3'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        // Disabled pins are released and read low
        if (dir_q[2*c +: 2] == atc_pkg::DIR_OUTPUT &&
            ccen_q[field_pos(c, atc_pkg::POS_ENABLE)]) begin
          o_chan_compare_oe[c] <= 1'b1;
          o_chan_compare_out[c] <= (cnt_q < chv_q[c]) ^
                                   ccen_q[field_pos(c, atc_pkg::POS_POLARITY)];
        end else begin
          o_chan_compare_oe[c] <= 1'b0;
          o_chan_compare_out[c] <= 1'b0;
        end
      end
      for (int c = 0; c < 3; c++) begin
        if (dir_q[2*c +: 2] == atc_pkg::DIR_OUTPUT &&
            ccen_q[field_pos(c, atc_pkg::POS_COMP_ENABLE)]) begin
          o_chan_compare_inv_oe[c] <= 1'b1;
          o_chan_compare_out_inv[c] <= !(cnt_q < chv_q[c]) ^
                                       ccen_q[field_pos(c, atc_pkg::POS_COMP_POLARITY)];
        end else begin
          o_chan_compare_inv_oe[c] <= 1'b0;
          o_chan_compare_out_inv[c] <= 1'b0;
        end
      end
    end
  end

  // Read value, registered in the address phase; unmapped reads give zero
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (i_haddr[7:0])
      atc_pkg::ADDR_CTRL: rd_val[2:0] = ctrl_q;
      atc_pkg::ADDR_DIR: rd_val[7:0] = dir_q;
      atc_pkg::ADDR_CHAN_ENABLE_POLARITY: rd_val[15:0] = ccen_q;
      atc_pkg::ADDR_COUNTER_VALUE: rd_val[15:0] = cnt_q;
      atc_pkg::ADDR_PRESCALE_DIVIDER: rd_val[15:0] = psc_q;
      atc_pkg::ADDR_RELOAD_LIMIT: rd_val[15:0] = reload_q;
      atc_pkg::ADDR_REPEAT_PERIOD: rd_val[REP_W-1:0] = rep_shadow_q;
      atc_pkg::ADDR_CHAN_VALUE_BASE: rd_val[15:0] = chv_q[0];
      atc_pkg::ADDR_CHAN_VALUE_BASE + 8'h04: rd_val[15:0] = chv_q[1];
      atc_pkg::ADDR_CHAN_VALUE_BASE + 8'h08: rd_val[15:0] = chv_q[2];
      atc_pkg::ADDR_CHAN_VALUE_BASE + 8'h0C: rd_val[15:0] = chv_q[3];
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_ok && !i_hwrite && !stall) begin
      o_hrdata <= rd_val;
    end
  end
endmodule : atc_timer

/* rtl/atc_pkg.sv */
// Package with register map, field layout and reset values of the timer core
package atc_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIR = 8'h04;
  localparam logic [7:0] ADDR_CHAN_ENABLE_POLARITY = 8'h20;
  localparam logic [7:0] ADDR_COUNTER_VALUE = 8'h24;
  localparam logic [7:0] ADDR_PRESCALE_DIVIDER = 8'h28;
  localparam logic [7:0] ADDR_RELOAD_LIMIT = 8'h2C;
  localparam logic [7:0] ADDR_REPEAT_PERIOD = 8'h30;
  localparam logic [7:0] ADDR_CHAN_VALUE_BASE = 8'h34;
  // Reset values
  localparam logic [15:0] RST_CHAN_ENABLE_POLARITY = 16'h0000;
  localparam logic [15:0] RST_COUNTER_VALUE = 16'h0000;
  localparam logic [15:0] RST_PRESCALE_DIVIDER = 16'h0000;
  localparam logic [15:0] RST_RELOAD_LIMIT = 16'hFFFF;
  localparam logic [7:0] RST_REPEAT_PERIOD = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [2:0] RST_CTRL = 3'h0;
  // Enable/polarity word layout: group of four bits per channel
  localparam int CHAN_GROUP_W = 4;
  localparam int POS_ENABLE = 0;
  localparam int POS_POLARITY = 1;
  localparam int POS_COMP_ENABLE = 2;
  localparam int POS_COMP_POLARITY = 3;
  localparam logic [15:0] CCEN_WRITE_MASK = 16'h3FFF;
  localparam logic [15:0] CCEN_POLARITY_MASK = 16'h2AAA;
  // Control register fields
  localparam int POS_COUNT_ENABLE = 0;
  localparam int POS_PROT_LO = 1;
  localparam logic [1:0] PROT_LEVEL_GUARD = 2'h2;
  // Direction select codes
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_IN_OWN = 2'h1;
  localparam logic [1:0] DIR_IN_PARTNER = 2'h2;
  localparam logic [1:0] DIR_IN_TRIGGER = 2'h3;
  // AHB transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage : atc_pkg

/* rtl/atc_tick_if.sv */
// Interface between timer core and its prescaler
`timescale 1ns/1ps
interface atc_tick_if #(parameter int W = 16);
  logic [W-1:0] prescale_value;
  logic restart;
  logic counter_clock;
  modport core (output prescale_value, output restart, input counter_clock);
  modport prs (input prescale_value, input restart, output counter_clock);
endinterface : atc_tick_if

/* rtl/atc_prescaler.sv */
// Prescaler that turns the timer clock into counter clock ticks
`timescale 1ns/1ps
module atc_prescaler #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Core side
  atc_tick_if.prs tick
);
  logic [W-1:0] div_q;

  // Widths the divider compare cannot serve are refused at elaboration
  if (W < 1 || W > 32) begin : g_bad_width
    $error("atc_prescaler: width out of range");
  end

  // Divide by prescale value plus one; a restart realigns the phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= '0;
    end else if (tick.restart || div_q >= tick.prescale_value) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // One tick per division period; restart is derived from this tick, so gating on it would loop
  assign tick.counter_clock = (div_q >= tick.prescale_value);
endmodule : atc_prescaler

/* verification/atc_checker.sv */
// Checker of the timer core pins and update events
`timescale 1ns/1ps
module atc_checker (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  // Pins and events
  input wire logic [3:0] o_chan_compare_out,
  input wire logic [3:0] o_chan_compare_oe,
  input wire logic [2:0] o_chan_compare_out_inv,
  input wire logic [2:0] o_chan_compare_inv_oe,
  input wire logic o_update_event
);
  logic wr_q;
  logic [15:0] en_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Marks a write data phase to the enable word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) wr_q <= 1'b0;
    else if (i_hready) wr_q <= i_hsel && i_htrans[1] && i_hwrite && i_haddr[7:0] == 8'h20;
  end
  // Copy of the enable word; polarity bits may differ under protection
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) en_q <= 16'h0000;
    else if (wr_q && i_hready) en_q <= i_hwdata[15:0];
  end
  a_chan1_off: assert property (!en_q[0] |=> !o_chan_compare_oe[0])
    else $error("channel 1 pin driven while disabled");
  a_chan2_off: assert property (!en_q[4] |=> !o_chan_compare_oe[1])
    else $error("channel 2 pin driven while disabled");
  a_chan3_off: assert property (!en_q[8] |=> !o_chan_compare_oe[2])
    else $error("channel 3 pin driven while disabled");
  a_chan4_off: assert property (!en_q[12] |=> !o_chan_compare_oe[3])
    else $error("channel 4 pin driven while disabled");
  a_comp1_off: assert property (!en_q[2] |=> !o_chan_compare_inv_oe[0])
    else $error("companion 1 driven while disabled");
  a_comp3_off: assert property (!en_q[10] |=> !o_chan_compare_inv_oe[2])
    else $error("companion 3 driven while disabled");
  a_pair_polarity: assert property (o_chan_compare_oe[0] && o_chan_compare_inv_oe[0]
    && $stable(en_q[3:0]) |-> (o_chan_compare_out[0] ^ o_chan_compare_out_inv[0])
    == !(en_q[1] ^ en_q[3])) else $error("channel 1 pair polarity wrong");
  a_update_pulse: assert property (o_update_event |=> !o_update_event)
    else $error("update event longer than one cycle");
  // Main scenarios reached
  c_update: cover property (o_update_event);
  c_pair_on: cover property (o_chan_compare_oe[0] && o_chan_compare_inv_oe[0]);
  c_comp3_on: cover property (o_chan_compare_inv_oe[2] && o_chan_compare_out_inv[2]);
endmodule : atc_checker

bind atc_timer atc_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_chan_compare_out(o_chan_compare_out),
  .o_chan_compare_oe(o_chan_compare_oe), .o_chan_compare_out_inv(o_chan_compare_out_inv),
  .o_chan_compare_inv_oe(o_chan_compare_inv_oe), .o_update_event(o_update_event));

/* verification/atc_pin_model.sv */
// Far-side model of the channel pins
`timescale 1ns/1ps
module atc_pin_model (
  // Clock
  input wire logic i_clk,
  // Bench command and pins
  input wire logic [3:0] i_level,
  input wire logic [3:0] i_compare,
  input wire logic [3:0] i_oe,
  output logic [3:0] o_chan_in,
  output logic [3:0] o_seen
);
  // Levels change only after an edge, as a synchronised source would
  always_ff @(posedge i_clk) o_chan_in <= i_level;
  // Pin levels as the far side sees them; a released pin falls to its pull-down
  always_ff @(posedge i_clk) o_seen <= i_compare & i_oe;
endmodule : atc_pin_model

/* verification/adv_timer_counter_chan_enable_bench.sv */
// Self-checking bench of the timer core
`timescale 1ns/1ps
module adv_timer_counter_chan_enable_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic trig = 1'b0;
  logic [3:0] lvl = 4'h0;
  wire logic hrdy, hresp, upd;
  wire logic [31:0] hrdata;
  wire logic [3:0] pin_in, cmp, cmp_oe, seen;
  wire logic [2:0] inv, inv_oe;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  atc_timer u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_chan_filtered_in(pin_in), .i_trigger_in(trig), .o_chan_compare_out(cmp),
    .o_chan_compare_oe(cmp_oe), .o_chan_compare_out_inv(inv),
    .o_chan_compare_inv_oe(inv_oe), .o_update_event(upd));
  atc_pin_model u_pins (.i_clk(clk), .i_level(lvl), .i_compare(cmp), .i_oe(cmp_oe),
    .o_chan_in(pin_in), .o_seen(seen));
  // Clock and hang guard; the whole run needs a few hundred cycles
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One single transfer; entered just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    // Address phase held until hready is seen high at a rising edge
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    // Data phase held likewise; read data and response taken at that edge
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask : rchk
  // Cycles until the next update pulse
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (upd !== 1'b1);
    @(posedge clk);
  endtask : wait_upd
  task automatic t_reset_values();
    logic [7:0] a[6] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h80};
    logic [31:0] e[6] = '{32'h0, 32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) rchk(a[i], e[i]);
    wr(8'h80, 32'h5A5A);
    rchk(8'h80, 32'h0);
  endtask : t_reset_values
  // Counter stopped at 0 and channel values 0, so the compare reference is low
  task automatic t_enable_pins();
    logic [15:0] w[5] = '{16'h0000, 16'h1555, 16'hFFFF, 16'h1111, 16'h0444};
    logic [13:0] e[5] = '{14'h0000, 14'h3C3F, 14'h3FF8, 14'h3C00, 14'h003F};
    for (int i = 0; i < 5; i++) begin
      wr(8'h20, {16'h0, w[i]});
      repeat (3) @(negedge clk);
      chk({18'h0, cmp_oe, cmp, inv_oe, inv}, {18'h0, e[i]});
      chk({28'h0, seen}, {28'h0, e[i][9:6]});
      @(posedge clk);
      rchk(8'h20, {16'h0, w[i] & 16'h3FFF});
    end
  endtask : t_enable_pins
  task automatic t_protect();
    logic [2:0] p[3] = '{3'h4, 3'h6, 3'h2};
    for (int i = 0; i < 3; i++) begin
      wr(8'h20, 32'h1555);
      wr(8'h00, {29'h0, p[i]});
      wr(8'h20, 32'h1575);
      rchk(8'h20, p[i] == 3'h2 ? 32'h1575 : 32'h1555);
    end
    wr(8'h00, 32'h0);
  endtask : t_protect
  // Counter moved between rise and fall tells the captured edge apart
  task automatic t_capture();
    logic [1:0] c[4] = '{2'h1, 2'h2, 2'h3, 2'h1};
    logic [1:0] m[4] = '{2'h1, 2'h3, 2'h1, 2'h0};
    logic [31:0] prev = 32'h0;
    int b;
    for (int i = 0; i < 4; i++) begin
      b = c[i] == 2'h3 ? 4 : c[i] - 1;
      wr(8'h20, 32'h0);
      wr(8'h04, {30'h0, c[i]});
      wr(8'h24, 32'h0A00 + i);
      wr(8'h20, {30'h0, m[i]});
      repeat (2) @(negedge clk);
      chk({31'h0, cmp_oe[0]}, 32'h0);
      @(posedge clk);
      {trig, lvl} <= 5'h1 << b;
      repeat (4) @(posedge clk);
      wr(8'h24, 32'h0B00 + i);
      {trig, lvl} <= 5'h0;
      repeat (4) @(posedge clk);
      if (m[i][0]) prev = m[i][1] ? 32'h0B00 + i : 32'h0A00 + i;
      rchk(8'h34, prev);
    end
    wr(8'h04, 32'h0);
  endtask : t_capture
  task automatic t_period();
    logic [15:0] r[3] = '{16'h0002, 16'h0003, 16'h0001};
    logic [15:0] p[3] = '{16'h0000, 16'h0001, 16'h0002};
    logic [7:0] n[3] = '{8'h00, 8'h02, 8'h01};
    int t;
    wr(8'h00, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(8'h2C, {16'h0, r[i]});
      wr(8'h28, {16'h0, p[i]});
      wr(8'h30, {24'h0, n[i]});
      repeat (3) wait_upd(t);
      chk(32'(t), 32'((r[i] + 1) * (p[i] + 1) * (n[i] + 1)));
    end
    wr(8'h28, 32'h0);
    wr(8'h30, 32'h0);
    repeat (2) wait_upd(t);
    wr(8'h30, 32'h3);
    wait_upd(t);
    chk(32'(t <= 3), 32'h1);
    repeat (2) wait_upd(t);
    chk(32'(t), 32'h8);
    wr(8'h2C, 32'h0);
    wr(8'h24, 32'h5);
    repeat (20) @(posedge clk);
    rchk(8'h24, 32'h5);
    wr(8'h00, 32'h0);
  endtask : t_period
  // Reset, then the scenarios in order
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset_values();
    t_enable_pins();
    t_protect();
    t_capture();
    t_period();
    end_of_test();
  end
endmodule : adv_timer_counter_chan_enable_bench
